// file: fsef_pkg.sv
// Constants and operation classes for the status-word flag logic
package fsef_pkg;

   localparam int          FLAG_W       = 6;
   localparam int          CC_W         = 4;
   localparam int          TOP_W        = 3;
   localparam int          WORD_W       = 16;

   // Status word bit positions
   localparam int          FLAG_LO      = 0;
   localparam int          FLAG_HI      = 5;
   localparam int          SF_POS       = 6;
   localparam int          ES_POS       = 7;
   localparam int          C0_POS       = 8;
   localparam int          C1_POS       = 9;
   localparam int          C2_POS       = 10;
   localparam int          TOP_LO       = 11;
   localparam int          TOP_HI       = 13;
   localparam int          C3_POS       = 14;
   localparam int          BUSY_POS     = 15;

   // Exception flag positions inside the flag field
   localparam int          INVALID_POS  = 0;
   localparam int          DENORMAL_POS = 1;
   localparam int          ZERODIV_POS  = 2;
   localparam int          OVERFLOW_POS = 3;
   localparam int          UNDERFLOW_POS = 4;
   localparam int          INEXACT_POS  = 5;

   // Condition code index inside the four-bit code
   localparam int          CC0          = 0;
   localparam int          CC1          = 1;
   localparam int          CC2          = 2;
   localparam int          CC3          = 3;

   // Control word mask field after initialize: all masked
   localparam logic [5:0]  MASK_INIT    = 6'h3F;
   localparam logic [5:0]  FLAGS_RESET  = 6'h00;
   localparam logic [3:0]  CC_RESET     = 4'h0;
   localparam logic [2:0]  TOP_RESET    = 3'h0;
   localparam logic [15:0] WORD_RESET   = 16'h0000;

   typedef enum logic [3:0] {
      OP_NONE      = 4'h0,
      OP_COMPARE   = 4'h1,
      OP_CMP_INT   = 4'h2,
      OP_EXAMINE   = 4'h3,
      OP_PREM      = 4'h4,
      OP_ROUND     = 4'h5,
      OP_TRIG      = 4'h6,
      OP_LOAD_MISC = 4'h7,
      OP_RESTORE   = 4'h8,
      OP_NO_CC     = 4'h9,
      OP_CTRL_LOAD = 4'hA,
      OP_CLEAR     = 4'hB,
      OP_INIT      = 4'hC
   } fsef_op_t;

endpackage

// file: fsef_seq_model.sv
// Sequencer and datapath stand-in that retires instructions
`timescale 1ns/1ps

module fsef_seq_model (
   input  wire logic         clock_in,     // Core clock
   output fsef_pkg::fsef_op_t op_class_out, // Group
   output logic              op_valid_out, // Retire strobe
   output logic [5:0]        exc_out,      // Exceptions
   output logic              fault_out,    // Stack fault
   output logic              over_out,     // Direction
   output logic [2:0]        cmp_out,      // Compare code
   output logic              sign_out,     // Sign
   output logic [2:0]        class_out,    // Operand class
   output logic [2:0]        quot_out,     // Quotient
   output logic              incomp_out,   // Incomplete
   output logic              rnd_up_out,   // Rounded up
   output logic              oor_out,      // Out of range
   output logic [15:0]       image_out,    // Loaded image
   output logic [5:0]        mask_out,     // Control mask
   output logic [2:0]        top_out       // Stack top
);
   initial
   begin
      op_class_out = fsef_pkg::OP_NONE;
      {op_valid_out, exc_out, fault_out, image_out, mask_out, top_out} = '0;
      {cmp_out, sign_out, class_out, quot_out, incomp_out, rnd_up_out, oor_out, over_out} = '0;
   end

   // Result fields are random; a real datapath may report any of them
   task automatic issue(input fsef_pkg::fsef_op_t op, input logic [5:0] e, input logic f, input logic [5:0] m);
      logic [31:0] r;
      r = $urandom;
      @(posedge clock_in);
      op_valid_out <= 1'b1;
      op_class_out <= op;
      {exc_out, fault_out, mask_out} <= {e, f, m};
      {cmp_out, sign_out, class_out, quot_out, incomp_out, rnd_up_out, oor_out, over_out} <= r[13:0];
      image_out <= r[31:16];
      top_out <= r[16:14];
   endtask

   task automatic idle();
      @(posedge clock_in);
      op_valid_out <= 1'b0;
   endtask
endmodule

// file: fsef_status_flags.sv
// Status-word exception, stack-fault and condition-code flag logic
//
// Function
// - Six exception flags in bits 0-5 set on each detected exception.
// - Summary bit 7 set while any unmasked exception flag is set.
// - Masked exceptions still set their flag but never the summary bit.
// - Summary bit set requests the exception handler.
// - Exception flags are sticky; only explicit clearing resets them.
// - Clear, initialize clear flags; restore overwrites them.
// - Bit 15 always mirrors the summary bit.
// - Stack-fault bit 6 set on register-stack overflow or underflow.
// - Invalid operand without stack fault leaves stack-fault bit unchanged.
// - On stack fault in compares, remainder, rounding, trig, moves and loads, condition bit one is 1 overflow, 0 underflow.
// - Stack-fault bit sticky; cleared by initialize, clear.
// - Compares write outcome to bits 0,2,3; bit one 0 or fault.
// - Integer-flag compares write bit one 0 or fault only.
// - Partial remainder: quotient bits to 0,3,1; bit two incomplete.
// - Rounding ops: bit one round-up or fault; others undefined.
// - Trig ops: bit two out-of-range; bit one round-up or fault, kept unchanged when out of range without fault.
// - Moves and loads: bit one 0 or fault; others undefined.
// - Restore loads each condition bit from image.
// - Free, control load, clear, nop, stores leave condition bits undefined.
// - Six control-word mask bits decide whether each exception is masked.
`timescale 1ns/1ps

module fsef_status_flags (
   input  wire logic                clock_in,        // Core clock
   input  wire logic                rst_in,          // Async reset, active high
   input  wire logic                op_valid_in,     // One instruction retires
   input  wire fsef_pkg::fsef_op_t  op_class_in,     // Instruction group
   input  wire logic [5:0]          exc_in,          // Detected exceptions
   input  wire logic                stack_fault_in,  // Stack over/underflow seen
   input  wire logic                stack_over_in,   // 1 overflow, 0 underflow
   input  wire logic [2:0]          cmp_result_in,   // Compare code {c3,c2,c0}
   input  wire logic                sign_in,         // Examined operand sign
   input  wire logic [2:0]          class_in,        // Examined class {c3,c2,c0}
   input  wire logic [2:0]          quotient_in,     // Quotient bits 2..0
   input  wire logic                incomplete_in,   // Reduction incomplete
   input  wire logic                round_up_in,     // Last rounding went up
   input  wire logic                out_of_range_in, // Trig source out of range
   input  wire logic [15:0]         image_in,        // Loaded status image
   input  wire logic [5:0]          ctrl_mask_in,    // Loaded control mask bits
   input  wire logic [2:0]          top_in,          // Stack top pointer
   output logic      [15:0]         status_word_out, // Status word
   output logic      [5:0]          mask_out,        // Current mask bits
   output logic                     handler_req_out  // Exception handler request
);

   logic                fire;
   logic                do_clear;
   logic                do_load;
   logic                do_mask_load;
   logic [5:0]          exc_set;
   logic [5:0]          flags_d;
   logic [5:0]          flags_q;
   logic                sf_d;
   logic                sf_q;
   logic [5:0]          mask_d;
   logic [5:0]          mask_q;
   logic                es_d;
   logic [3:0]          cc_d;
   logic [3:0]          cc_q;
   logic [3:0]          image_cc;
   logic [15:0]         word_d;
   logic [15:0]         word_q;
   logic                es_q;

   // Initialize: masks back to all masked, codes to zero
   function automatic logic reinit(input fsef_pkg::fsef_op_t op);
      reinit = (op == fsef_pkg::OP_INIT);
   endfunction

   // Clears flags: clear or initialize
   function automatic logic clears_flags(input fsef_pkg::fsef_op_t op);
      clears_flags = (op == fsef_pkg::OP_CLEAR) || reinit(op);
   endfunction

   // Restore overwrites flags and codes from an image
   function automatic logic loads_image(input fsef_pkg::fsef_op_t op);
      loads_image = (op == fsef_pkg::OP_RESTORE);
   endfunction

   // Mask bits follow the operand on a control load or a restore
   function automatic logic loads_mask(input fsef_pkg::fsef_op_t op);
      loads_mask = (op == fsef_pkg::OP_CTRL_LOAD) || loads_image(op);
   endfunction

   // Summary: any flag whose mask bit is clear
   function automatic logic unmasked_any(input logic [5:0] flags,
                                         input logic [5:0] masks);
      unmasked_any = |(flags & ~masks);
   endfunction

   // Condition bit one: fault direction wins over the normal meaning
   function automatic logic fault_c1(input logic fault,
                                     input logic over,
                                     input logic alt);
      fault_c1 = fault ? over : alt;
   endfunction

   assign fire         = op_valid_in;
   assign do_clear     = fire && clears_flags(op_class_in);
   assign do_load      = fire && loads_image(op_class_in);
   assign do_mask_load = fire && loads_mask(op_class_in);
   // Exceptions count only alongside a retiring instruction
   assign exc_set      = fire ? exc_in : fsef_pkg::FLAGS_RESET;

   // Exception flags
   fsef_sticky #(
      .W (fsef_pkg::FLAG_W)
   ) u_exc_flags (
      .clock_in    (clock_in),
      .rst_in      (rst_in),
      .clear_in    (do_clear),
      .load_in     (do_load),
      .load_val_in (image_in[fsef_pkg::FLAG_HI:fsef_pkg::FLAG_LO]),
      .set_in      (exc_set),
      .next_out    (flags_d),
      .q_out       (flags_q)
   );

   // Stack-fault flag; only a real stack fault sets it
   fsef_sticky #(
      .W (1)
   ) u_stack_fault (
      .clock_in    (clock_in),
      .rst_in      (rst_in),
      .clear_in    (do_clear),
      .load_in     (do_load),
      .load_val_in (image_in[fsef_pkg::SF_POS]),
      .set_in      (fire && stack_fault_in),
      .next_out    (sf_d),
      .q_out       (sf_q)
   );

   // Mask bits of the control word
   always_comb
   begin
      mask_d = mask_q;
      if (fire && reinit(op_class_in))
      begin
         mask_d = fsef_pkg::MASK_INIT;
      end
      else if (do_mask_load)
      begin
         mask_d = ctrl_mask_in;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         // Out of reset every exception is masked, as after initialize
         mask_q <= fsef_pkg::MASK_INIT;
      end
      else
      begin
         mask_q <= mask_d;
      end
   end

   // Summary follows the flags and masks that hold after this edge,
   // so an unmasking control load raises it without a new exception
   assign es_d = unmasked_any(flags_d, mask_d);

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         es_q <= 1'b0;
      end
      else
      begin
         // Own flop keeps the request one flop deep, like the word
         es_q <= es_d;
      end
   end

   // Condition codes carried in a restored image
   assign image_cc[fsef_pkg::CC0] = image_in[fsef_pkg::C0_POS];
   assign image_cc[fsef_pkg::CC1] = image_in[fsef_pkg::C1_POS];
   assign image_cc[fsef_pkg::CC2] = image_in[fsef_pkg::C2_POS];
   assign image_cc[fsef_pkg::CC3] = image_in[fsef_pkg::C3_POS];

   // Undefined condition bits keep their old value
   always_comb
   begin
      cc_d = cc_q;
      if (fire)
      begin
         case (op_class_in)
            fsef_pkg::OP_COMPARE:
            begin
               cc_d[fsef_pkg::CC0] = cmp_result_in[0];
               cc_d[fsef_pkg::CC2] = cmp_result_in[1];
               cc_d[fsef_pkg::CC3] = cmp_result_in[2];
               cc_d[fsef_pkg::CC1] = fault_c1(stack_fault_in,
                                              stack_over_in, 1'b0);
            end
            fsef_pkg::OP_CMP_INT:
            begin
               cc_d[fsef_pkg::CC1] = fault_c1(stack_fault_in,
                                              stack_over_in, 1'b0);
            end
            fsef_pkg::OP_EXAMINE:
            begin
               cc_d[fsef_pkg::CC0] = class_in[0];
               cc_d[fsef_pkg::CC2] = class_in[1];
               cc_d[fsef_pkg::CC3] = class_in[2];
               cc_d[fsef_pkg::CC1] = sign_in;
            end
            fsef_pkg::OP_PREM:
            begin
               cc_d[fsef_pkg::CC0] = quotient_in[2];
               cc_d[fsef_pkg::CC3] = quotient_in[1];
               cc_d[fsef_pkg::CC2] = incomplete_in;
               cc_d[fsef_pkg::CC1] = fault_c1(stack_fault_in,
                                              stack_over_in,
                                              quotient_in[0]);
            end
            fsef_pkg::OP_ROUND:
            begin
               cc_d[fsef_pkg::CC1] = fault_c1(stack_fault_in,
                                              stack_over_in,
                                              round_up_in);
            end
            fsef_pkg::OP_TRIG:
            begin
               cc_d[fsef_pkg::CC2] = out_of_range_in;
               // Bit one is undefined when out of range; without a stack fault it is left alone
               if (stack_fault_in || !out_of_range_in)
               begin
                  cc_d[fsef_pkg::CC1] = fault_c1(stack_fault_in,
                                                 stack_over_in,
                                                 round_up_in);
               end
            end
            fsef_pkg::OP_LOAD_MISC:
            begin
               cc_d[fsef_pkg::CC1] = fault_c1(stack_fault_in,
                                              stack_over_in, 1'b0);
            end
            fsef_pkg::OP_RESTORE:
            begin
               cc_d = image_cc;
            end
            fsef_pkg::OP_INIT:
            begin
               cc_d = fsef_pkg::CC_RESET;
            end
            default:
            begin
               cc_d = cc_q;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cc_q <= fsef_pkg::CC_RESET;
      end
      else
      begin
         cc_q <= cc_d;
      end
   end

   // Whole word assembled from next values so it is one flop deep
   always_comb
   begin
      word_d = fsef_pkg::WORD_RESET;
      word_d[fsef_pkg::FLAG_HI:fsef_pkg::FLAG_LO] = flags_d;
      word_d[fsef_pkg::SF_POS]   = sf_d;
      word_d[fsef_pkg::ES_POS]   = es_d;
      word_d[fsef_pkg::C0_POS]   = cc_d[fsef_pkg::CC0];
      word_d[fsef_pkg::C1_POS]   = cc_d[fsef_pkg::CC1];
      word_d[fsef_pkg::C2_POS]   = cc_d[fsef_pkg::CC2];
      word_d[fsef_pkg::C3_POS]   = cc_d[fsef_pkg::CC3];
      // Pointer is only mirrored; the stack logic owns it
      word_d[fsef_pkg::TOP_HI:fsef_pkg::TOP_LO] = top_in;
      word_d[fsef_pkg::BUSY_POS] = es_d;
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         word_q <= fsef_pkg::WORD_RESET;
      end
      else
      begin
         word_q <= word_d;
      end
   end

   assign status_word_out = word_q;
   assign mask_out        = mask_q;
   assign handler_req_out = es_q;

endmodule

// file: fsef_status_flags_chk.sv
// Port-level assertions for the status-word flag logic
`timescale 1ns/1ps

module fsef_status_flags_chk (
   input wire logic               clock_in,        // Core clock
   input wire logic               rst_in,          // Async reset
   input wire logic               op_valid_in,     // Op taken
   input wire fsef_pkg::fsef_op_t op_class_in,     // Group
   input wire logic [5:0]         exc_in,          // Exceptions
   input wire logic               stack_fault_in,  // Stack fault
   input wire logic               stack_over_in,   // Direction
   input wire logic [2:0]         quotient_in,     // Quotient
   input wire logic               incomplete_in,   // Incomplete
   input wire logic               out_of_range_in, // Trig range
   input wire logic [15:0]        status_word_out, // Status word
   input wire logic [5:0]         mask_out,        // Masks
   input wire logic               handler_req_out  // Handler request
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);

   a_bit15_mirror: assert property (status_word_out[15] == status_word_out[7]) else $error("bit 15 differs");
   a_handler_tracks_es: assert property (handler_req_out == status_word_out[7]) else $error("handler request");
   a_es_summary: assert property (status_word_out[7] == |(status_word_out[5:0] & ~mask_out))
      else $error("summary bit wrong");
   a_flags_sticky: assert property (!op_valid_in |=> $stable(status_word_out[6:0]))
      else $error("flags moved without op");
   a_exc_sets_flag: assert property (op_valid_in |=> (status_word_out[5:0] & $past(exc_in)) == $past(exc_in))
      else $error("exception flag not set");
   a_fault_sets_sf: assert property (op_valid_in && stack_fault_in |=> status_word_out[6])
      else $error("stack fault bit not set");
   a_fault_dir_c1: assert property (op_valid_in && stack_fault_in && op_class_in inside {fsef_pkg::OP_COMPARE,
      fsef_pkg::OP_CMP_INT, fsef_pkg::OP_ROUND, fsef_pkg::OP_LOAD_MISC, fsef_pkg::OP_TRIG, fsef_pkg::OP_PREM}
      |=> status_word_out[9] == $past(stack_over_in)) else $error("fault direction wrong");
   a_clear_drops: assert property (op_valid_in && op_class_in == fsef_pkg::OP_CLEAR && exc_in == 6'h00
      && !stack_fault_in |=> status_word_out[7:0] == 8'h00) else $error("clear left flags");
   a_init_zeroes: assert property (op_valid_in && op_class_in == fsef_pkg::OP_INIT |=> mask_out == 6'h3F
      && status_word_out[14] == 1'b0 && status_word_out[10:8] == 3'h0) else $error("init state wrong");
   a_prem_map: assert property (op_valid_in && op_class_in == fsef_pkg::OP_PREM && !stack_fault_in |=>
      {status_word_out[8], status_word_out[14], status_word_out[9], status_word_out[10]}
      == $past({quotient_in, incomplete_in})) else $error("remainder bits wrong");
   a_trig_range: assert property (op_valid_in && op_class_in == fsef_pkg::OP_TRIG |=>
      status_word_out[10] == $past(out_of_range_in)) else $error("range bit wrong");

   c_prem: cover property (op_valid_in && op_class_in == fsef_pkg::OP_PREM);
   c_handler: cover property ($rose(handler_req_out));
   c_fault: cover property (op_valid_in && stack_fault_in);
endmodule

bind fsef_status_flags fsef_status_flags_chk i_fsef_status_flags_chk (
   .clock_in(clock_in), .rst_in(rst_in), .op_valid_in(op_valid_in), .op_class_in(op_class_in),
   .exc_in(exc_in), .stack_fault_in(stack_fault_in), .stack_over_in(stack_over_in),
   .quotient_in(quotient_in), .incomplete_in(incomplete_in), .out_of_range_in(out_of_range_in),
   .status_word_out(status_word_out), .mask_out(mask_out), .handler_req_out(handler_req_out));

// file: fsef_sticky.sv
// Sticky flag bank with clear, overwrite and set-wins priority
`timescale 1ns/1ps

module fsef_sticky #(
   parameter int W = 6
) (
   input  wire logic         clock_in,    // Core clock
   input  wire logic         rst_in,      // Async reset, active high
   input  wire logic         clear_in,    // Clear all bits
   input  wire logic         load_in,     // Overwrite with load value
   input  wire logic [W-1:0] load_val_in, // Value to overwrite with
   input  wire logic [W-1:0] set_in,      // Per-bit set events
   output logic      [W-1:0] next_out,    // Value taken at next edge
   output logic      [W-1:0] q_out        // Held flags
);

   logic [W-1:0] base;

   always_comb
   begin
      base = q_out;
      if (load_in)
      begin
         base = load_val_in;
      end
      else if (clear_in)
      begin
         base = '0;
      end
      // An event in the clearing cycle must survive the clear
      next_out = base | set_in;
   end

   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         q_out <= '0;
      end
      else
      begin
         q_out <= next_out;
      end
   end

endmodule

// file: tb_fsef_status_flags.sv
// Self-checking bench for the status-word flag logic
`timescale 1ns/1ps

module tb_fsef_status_flags;
   logic               clock_in, rst_in, v, fault, over, sign, incomp, rup, oor, handler, e_sf;
   fsef_pkg::fsef_op_t cls;
   logic [5:0]         exc, cmask, mask, e_flag, e_mask;
   logic [2:0]         cmp, ocls, quot, top;
   logic [3:0]         e_cc;
   logic [15:0]        image, word;
   logic [22:0]        exp_q[$];
   int                 n_mismatch, samples_checked;

   fsef_seq_model i_fsef_seq_model (.clock_in(clock_in), .op_class_out(cls), .op_valid_out(v), .exc_out(exc),
      .fault_out(fault), .over_out(over), .cmp_out(cmp), .sign_out(sign), .class_out(ocls), .quot_out(quot),
      .incomp_out(incomp), .rnd_up_out(rup), .oor_out(oor), .image_out(image), .mask_out(cmask), .top_out(top));

   fsef_status_flags i_fsef_status_flags (.clock_in(clock_in), .rst_in(rst_in), .op_valid_in(v),
      .op_class_in(cls), .exc_in(exc), .stack_fault_in(fault), .stack_over_in(over), .cmp_result_in(cmp),
      .sign_in(sign), .class_in(ocls), .quotient_in(quot), .incomplete_in(incomp), .round_up_in(rup),
      .out_of_range_in(oor), .image_in(image), .ctrl_mask_in(cmask), .top_in(top),
      .status_word_out(word), .mask_out(mask), .handler_req_out(handler));

   initial
   begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   task automatic chk(input string nm, input logic [22:0] e, input logic [22:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Reference state advances at issue time, so back-to-back ops chain
   task automatic predict();
      logic es;
      if (cls inside {fsef_pkg::OP_INIT, fsef_pkg::OP_CLEAR})
         {e_sf, e_flag} = 7'h00;
      if (cls == fsef_pkg::OP_RESTORE)
         {e_sf, e_flag} = image[6:0];
      {e_sf, e_flag} = {e_sf | fault, e_flag | exc};
      if (cls inside {fsef_pkg::OP_RESTORE, fsef_pkg::OP_CTRL_LOAD})
         e_mask = cmask;
      case (cls)
         fsef_pkg::OP_INIT: {e_mask, e_cc} = {6'h3F, 4'h0};
         fsef_pkg::OP_COMPARE: e_cc = {cmp[2:1], fault & over, cmp[0]};
         fsef_pkg::OP_CMP_INT, fsef_pkg::OP_LOAD_MISC: e_cc[1] = fault & over;
         fsef_pkg::OP_EXAMINE: e_cc = {ocls[2:1], sign, ocls[0]};
         fsef_pkg::OP_PREM: e_cc = {quot[1], incomp, fault ? over : quot[0], quot[2]};
         fsef_pkg::OP_ROUND: e_cc[1] = fault ? over : rup;
         fsef_pkg::OP_TRIG: e_cc[2:1] = {oor, fault ? over : (oor ? e_cc[1] : rup)};
         fsef_pkg::OP_RESTORE: e_cc = {image[14], image[10:8]};
         default: ;
      endcase
      es = |(e_flag & ~e_mask);
      exp_q.push_back({es, e_mask, es, e_cc[3], top, e_cc[2:0], es, e_sf, e_flag});
   endtask

   task automatic drive_op(input fsef_pkg::fsef_op_t op, input logic [5:0] e, input logic f, input logic [5:0] m);
      i_fsef_seq_model.issue(op, e, f, m);
      #1;
      predict();
   endtask

   task automatic do_reset();
      // Let the last pending result be checked before reset wipes it
      @(posedge clock_in);
      rst_in <= 1'b1;
      repeat (12) @(posedge clock_in);
      #1;
      chk("reset", {1'b0, 6'h3F, 16'h0000}, {handler, mask, word});
      {e_flag, e_sf, e_cc, e_mask} = {6'h00, 1'b0, 4'h0, 6'h3F};
      @(posedge clock_in);
      rst_in <= 1'b0;
   endtask

   initial
   forever
   begin
      @(posedge clock_in);
      if (v === 1'b1)
      begin
         #1;
         chk("status", exp_q.pop_front(), {handler, mask, word});
      end
   end

   initial
   begin
      #50000;
      n_mismatch++;
      close_out();
   end

   initial
   begin
      rst_in = 1'b1;
      n_mismatch = 0;
      samples_checked = 0;
      void'($urandom(32'h1509));
      do_reset();
      drive_op(fsef_pkg::OP_INIT, 6'h00, 1'b0, 6'h00);
      drive_op(fsef_pkg::OP_ROUND, 6'h20, 1'b0, 6'h00);
      drive_op(fsef_pkg::OP_CTRL_LOAD, 6'h00, 1'b0, 6'h1F);
      drive_op(fsef_pkg::OP_COMPARE, 6'h01, 1'b1, 6'h00);
      drive_op(fsef_pkg::OP_NO_CC, 6'h00, 1'b0, 6'h00);
      drive_op(fsef_pkg::OP_CLEAR, 6'h00, 1'b0, 6'h00);
      repeat (300)
      begin
         drive_op(fsef_pkg::fsef_op_t'($urandom_range(12, 0)), 6'($urandom & $urandom & $urandom),
            ($urandom_range(7, 0) == 0), 6'($urandom));
         if ($urandom_range(3, 0) == 0)
            i_fsef_seq_model.idle();
      end
      i_fsef_seq_model.idle();
      do_reset();
      drive_op(fsef_pkg::OP_TRIG, 6'h3F, 1'b1, 6'h00);
      drive_op(fsef_pkg::OP_CLEAR, 6'h00, 1'b0, 6'h00);
      i_fsef_seq_model.idle();
      repeat (2) @(posedge clock_in);
      close_out();
   end
endmodule
